// *** design/cell_regs_pkg.sv ***
// Package with register map, field positions and reset values of the port register bank.
package cell_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int NUM_PORTS = 8;
	localparam int PORT_SEL_LSB = 5;
	localparam int PORT_SEL_W = 3;
	// Offsets within a 32-byte port window; the upper three address bits select the port.
	localparam logic [4:0] OFS_TX_COUNT_LATCH = 5'h01;
	localparam logic [4:0] OFS_TX_CELL_COUNT_HIGH = 5'h02;
	localparam logic [4:0] OFS_TX_CELL_COUNT_LOW = 5'h03;
	localparam logic [4:0] OFS_TX_CONTROL1 = 5'h06;
	localparam logic [4:0] OFS_RX_CONTROL2 = 5'h1A;
	localparam logic [4:0] OFS_PORT_STATUS = 5'h18;
	// Shared registers sit at full addresses.
	localparam logic [7:0] ADDR_IDLE_PAYLOAD_BYTE = 8'h04;
	localparam logic [7:0] ADDR_HEADER_ERROR_PATTERN = 8'h05;
	localparam logic [7:0] ADDR_PORT_INTERRUPT_SUMMARY = 8'h08;
	localparam logic [7:0] RST_IDLE_PAYLOAD = 8'h6A;
	localparam logic [7:0] RST_HEADER_ERROR_PATTERN = 8'h29;
	localparam logic [7:0] RST_TX_CONTROL1 = 8'h05;
	localparam logic [7:0] RST_RX_CONTROL2 = 8'h00;
	localparam logic [7:0] LATCH_WRITE_VALUE = 8'h00;
	// Error pattern fields.
	localparam int BAD_CNT_LSB = 0;
	localparam int BAD_CNT_W = 3;
	localparam int GOOD_CNT_LSB = 3;
	localparam int GOOD_CNT_W = 5;
	// Transmit control 1 bit positions.
	localparam int TXC_GEN_EN = 0;
	localparam int TXC_ERR_INS_EN = 1;
	localparam int TXC_PAR_MASK = 6;
	// Receive control 2 bit positions.
	localparam int RXC_OVR_MASK = 3;
	localparam int RXC_DEL_MASK = 4;
	localparam int RXC_EXT_MASK = 5;
	// Port status bit positions.
	localparam int PS_OVERRUN = 0;
	localparam int PS_DEL_CHANGE = 1;
	localparam int PS_DEL_LOST = 2;
	localparam int PS_RX_MODE = 3;
	localparam int PS_DEL_LSB = 4;
	localparam int PS_DEL_MSB = 5;
	localparam int PS_PARITY = 6;
	localparam int PS_EXT_EVENT = 7;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	typedef enum logic {PHASE_GOOD, PHASE_BAD} err_phase_e;
endpackage

// *** design/tx_counter_status_interrupt_regs.sv ***
// Register bank: transmit cell counts, idle byte, error pattern, port status and interrupt summary.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Transmit cell count readable as upper and lower read-only bytes.
// - Both count bytes shared by all ports, same at every alias.
// - Latched count equals non-idle cells sent on that port since its last latch.
// - Count byte reads return the last latched value, never the live count.
// - Writing zero to a port latch copies its count and clears it.
// - Idle cell payload byte is programmable, resets to 6A hex.
// - Bits 2:0 of error pattern give count of bad-check cells.
// - Bits 7:3 of error pattern give count of good-check cells.
// - While enabled, alternate good then bad periods until disabled.
// - Error insertion applies whether or not check generation is enabled.
// - Status bit 0 sets on overrun, interrupts when masked on, clears on read.
// - Status bit 1 sets on delineation change, interrupts if masked, read-clears.
// - Status bit 2 shows delineation lost, resets to one.
// - Status bit 3 shows receiver mode, valid only with correction enabled.
// - Status bits 5:4 show hunt, presync or sync delineation state.
// - Status bit 6 sets on transmit parity error, interrupts if masked, read-clears.
// - Status bit 7 sets on external input rising edge, interrupts if masked, read-clears.
// - Summary register has one bit per port showing pending interrupt.
// - Reading a port status clears that port summary bit too.
// - Only masked-on events set the summary bit.
module tx_counter_status_interrupt_regs
	import cell_regs_pkg::*;
#(
	parameter int NPORT = NUM_PORTS
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Register port.
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Transmit datapath per port.
	input wire logic [NPORT-1:0] txCellSent,
	input wire logic [NPORT-1:0] txCellIsIdle,
	input wire logic [NPORT-1:0] txParityError,
	output logic [NPORT-1:0] txCorruptCheck,
	output logic [NPORT-1:0] checkByteGenerateEnable,
	output logic [7:0] idlePayloadValue,
	// Receive status per port.
	input wire logic [NPORT-1:0] rxOverrun,
	input wire logic [NPORT-1:0] lossOfDelineation,
	input wire logic [NPORT-1:0] receiverModeState,
	input wire logic [NPORT-1:0] delineationStateLsb,
	input wire logic [NPORT-1:0] delineationStateMsb,
	// External status pins.
	input wire logic [NPORT-1:0] externalStatusPin,
	// Interrupt.
	output logic irq_n
);
	if (NPORT != NUM_PORTS) begin : g_portCheck
		$error("Port count must match the eight-port address map.");
	end

	// Address decode.
	logic [PORT_SEL_W-1:0] selPort;
	logic [4:0] selOfs;
	assign selPort = regAddr[ADDR_W-1:PORT_SEL_LSB];
	assign selOfs = regAddr[PORT_SEL_LSB-1:0];

	// Shared and per-port registers.
	logic [7:0] idlePayload_ff, nxt_idlePayload;
	logic [7:0] errPattern_ff, nxt_errPattern;
	logic [15:0] latchedCount_ff, nxt_latchedCount;
	logic [7:0] rdData_ff, nxt_rdData;
	logic irqN_ff, nxt_irqN;
	logic [15:0] runCount_ff [NPORT];
	logic [15:0] nxt_runCount [NPORT];
	logic [7:0] txCtl_ff [NPORT];
	logic [7:0] nxt_txCtl [NPORT];
	logic [7:0] rxCtl_ff [NPORT];
	logic [7:0] nxt_rxCtl [NPORT];
	logic [NPORT-1:0] overrunFlag_ff, nxt_overrunFlag;
	logic [NPORT-1:0] delChangeFlag_ff, nxt_delChangeFlag;
	logic [NPORT-1:0] parityFlag_ff, nxt_parityFlag;
	logic [NPORT-1:0] extFlag_ff, nxt_extFlag;
	logic [NPORT-1:0] summary_ff, nxt_summary;
	logic [NPORT-1:0] lodPrev_ff, nxt_lodPrev;
	logic [NPORT-1:0] extSync1_ff, extSync2_ff, extPrev_ff;
	logic [NPORT-1:0] corrupt_ff, nxt_corrupt;
	logic [NPORT-1:0] genEn_ff, nxt_genEn;
	logic [NPORT-1:0] wrPort, rdPort;
	err_phase_e phase_ff [NPORT];
	err_phase_e nxt_phase [NPORT];
	logic [GOOD_CNT_W-1:0] phaseCnt_ff [NPORT];
	logic [GOOD_CNT_W-1:0] nxt_phaseCnt [NPORT];

	logic [7:0] statusView [NPORT];
	logic [BAD_CNT_W-1:0] badLen;
	logic [GOOD_CNT_W-1:0] goodLen;
	assign badLen = errPattern_ff[BAD_CNT_LSB +: BAD_CNT_W];
	assign goodLen = errPattern_ff[GOOD_CNT_LSB +: GOOD_CNT_W];

	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			statusView[p] = 8'h00;
			statusView[p][PS_OVERRUN] = overrunFlag_ff[p];
			statusView[p][PS_DEL_CHANGE] = delChangeFlag_ff[p];
			statusView[p][PS_DEL_LOST] = lodPrev_ff[p];
			statusView[p][PS_RX_MODE] = receiverModeState[p];
			statusView[p][PS_DEL_LSB] = delineationStateLsb[p];
			statusView[p][PS_DEL_MSB] = delineationStateMsb[p];
			statusView[p][PS_PARITY] = parityFlag_ff[p];
			statusView[p][PS_EXT_EVENT] = extFlag_ff[p];
		end
	end

	// Per-port strobe decode.
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			wrPort[p] = regWrite && selPort == PORT_SEL_W'(p);
			rdPort[p] = regRead && selPort == PORT_SEL_W'(p) && selOfs == OFS_PORT_STATUS;
		end
	end

	// Register writes and running counts.
	always_comb begin
		nxt_idlePayload = idlePayload_ff;
		nxt_errPattern = errPattern_ff;
		nxt_latchedCount = latchedCount_ff;
		if (regWrite && regAddr == ADDR_IDLE_PAYLOAD_BYTE) begin
			nxt_idlePayload = regWrData;
		end
		if (regWrite && regAddr == ADDR_HEADER_ERROR_PATTERN) begin
			nxt_errPattern = regWrData;
		end
		for (int p = 0; p < NPORT; p++) begin
			nxt_txCtl[p] = txCtl_ff[p];
			nxt_rxCtl[p] = rxCtl_ff[p];
			if (wrPort[p] && selOfs == OFS_TX_CONTROL1) begin
				nxt_txCtl[p] = regWrData;
			end
			if (wrPort[p] && selOfs == OFS_RX_CONTROL2) begin
				nxt_rxCtl[p] = regWrData;
			end
			nxt_runCount[p] = runCount_ff[p];
			if (txCellSent[p] && !txCellIsIdle[p]) begin
				nxt_runCount[p] = runCount_ff[p] + COUNT_ONE;
			end
			// Latch and clear; a cell in the same cycle starts the new count.
			if (wrPort[p] && selOfs == OFS_TX_COUNT_LATCH && regWrData == LATCH_WRITE_VALUE) begin
				nxt_latchedCount = runCount_ff[p];
				nxt_runCount[p] = (txCellSent[p] && !txCellIsIdle[p]) ? COUNT_ONE : COUNT_ZERO;
			end
		end
	end

	// Event flags, summary and interrupt.
	always_comb begin
		logic intReq;
		intReq = 1'b0;
		for (int p = 0; p < NPORT; p++) begin
			nxt_lodPrev[p] = lossOfDelineation[p];
			// Set beats read clear, so no event is lost.
			nxt_overrunFlag[p] = (overrunFlag_ff[p] && !rdPort[p]) || rxOverrun[p];
			nxt_delChangeFlag[p] = (delChangeFlag_ff[p] && !rdPort[p])
				|| (lossOfDelineation[p] != lodPrev_ff[p]);
			nxt_parityFlag[p] = (parityFlag_ff[p] && !rdPort[p]) || txParityError[p];
			nxt_extFlag[p] = (extFlag_ff[p] && !rdPort[p]) || (extSync2_ff[p] && !extPrev_ff[p]);
			intReq = (rxOverrun[p] && rxCtl_ff[p][RXC_OVR_MASK])
				|| ((lossOfDelineation[p] != lodPrev_ff[p]) && rxCtl_ff[p][RXC_DEL_MASK])
				|| (txParityError[p] && txCtl_ff[p][TXC_PAR_MASK])
				|| (extSync2_ff[p] && !extPrev_ff[p] && rxCtl_ff[p][RXC_EXT_MASK]);
			nxt_summary[p] = (summary_ff[p] && !rdPort[p]) || intReq;
		end
		nxt_irqN = ~|nxt_summary;
	end

	// Read data; shared full addresses win over the per-port offset decode.
	always_comb begin
		nxt_rdData = 8'h00;
		if (regRead) begin
			case (regAddr)
				ADDR_IDLE_PAYLOAD_BYTE: begin
					nxt_rdData = idlePayload_ff;
				end
				ADDR_HEADER_ERROR_PATTERN: begin
					nxt_rdData = errPattern_ff;
				end
				ADDR_PORT_INTERRUPT_SUMMARY: begin
					nxt_rdData = summary_ff;
				end
				default: begin
					case (selOfs)
						OFS_TX_CELL_COUNT_HIGH: begin
							nxt_rdData = latchedCount_ff[15:8];
						end
						OFS_TX_CELL_COUNT_LOW: begin
							nxt_rdData = latchedCount_ff[7:0];
						end
						OFS_TX_CONTROL1: begin
							nxt_rdData = txCtl_ff[selPort];
						end
						OFS_RX_CONTROL2: begin
							nxt_rdData = rxCtl_ff[selPort];
						end
						OFS_PORT_STATUS: begin
							nxt_rdData = statusView[selPort];
						end
						default: begin
							nxt_rdData = 8'h00;
						end
					endcase
				end
			endcase
		end
	end

	// Error insertion sequencing per port.
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			nxt_phase[p] = phase_ff[p];
			nxt_phaseCnt[p] = phaseCnt_ff[p];
			nxt_genEn[p] = txCtl_ff[p][TXC_GEN_EN];
			if (!txCtl_ff[p][TXC_ERR_INS_EN]) begin
				nxt_phase[p] = PHASE_GOOD;
				nxt_phaseCnt[p] = '0;
			end else if (txCellSent[p]) begin
				case (phase_ff[p])
					PHASE_GOOD: begin
						if (phaseCnt_ff[p] + 5'h01 >= goodLen) begin
							nxt_phase[p] = (badLen != '0) ? PHASE_BAD : PHASE_GOOD;
							nxt_phaseCnt[p] = '0;
						end else begin
							nxt_phaseCnt[p] = phaseCnt_ff[p] + 5'h01;
						end
					end
					PHASE_BAD: begin
						if (phaseCnt_ff[p] + 5'h01 >= {2'b00, badLen}) begin
							nxt_phase[p] = (goodLen != '0) ? PHASE_GOOD : PHASE_BAD;
							nxt_phaseCnt[p] = '0;
						end else begin
							nxt_phaseCnt[p] = phaseCnt_ff[p] + 5'h01;
						end
					end
					default: begin
						nxt_phase[p] = PHASE_GOOD;
					end
				endcase
			end
			nxt_corrupt[p] = txCtl_ff[p][TXC_ERR_INS_EN] && (nxt_phase[p] == PHASE_BAD
				|| (goodLen == '0 && badLen != '0));
		end
	end

	// Shared registers.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			idlePayload_ff <= RST_IDLE_PAYLOAD;
			errPattern_ff <= RST_HEADER_ERROR_PATTERN;
			latchedCount_ff <= COUNT_ZERO;
			rdData_ff <= 8'h00;
			irqN_ff <= 1'b1;
		end else begin
			idlePayload_ff <= nxt_idlePayload;
			errPattern_ff <= nxt_errPattern;
			latchedCount_ff <= nxt_latchedCount;
			rdData_ff <= nxt_rdData;
			irqN_ff <= nxt_irqN;
		end
	end

	// The synchroniser has no reset; it settles on the pin level while reset is held.
	always_ff @(posedge clk_sys) begin
		extSync1_ff <= externalStatusPin;
		extSync2_ff <= extSync1_ff;
	end

	// Event flags and summary.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			overrunFlag_ff <= '0;
			delChangeFlag_ff <= '0;
			parityFlag_ff <= '0;
			extFlag_ff <= '0;
			summary_ff <= '0;
			lodPrev_ff <= '1;
			extPrev_ff <= '0;
		end else begin
			overrunFlag_ff <= nxt_overrunFlag;
			delChangeFlag_ff <= nxt_delChangeFlag;
			parityFlag_ff <= nxt_parityFlag;
			extFlag_ff <= nxt_extFlag;
			summary_ff <= nxt_summary;
			lodPrev_ff <= nxt_lodPrev;
			extPrev_ff <= extSync2_ff;
		end
	end

	// Per-port control registers and running counts.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int p = 0; p < NPORT; p++) begin
				runCount_ff[p] <= COUNT_ZERO;
				txCtl_ff[p] <= RST_TX_CONTROL1;
				rxCtl_ff[p] <= RST_RX_CONTROL2;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				runCount_ff[p] <= nxt_runCount[p];
				txCtl_ff[p] <= nxt_txCtl[p];
				rxCtl_ff[p] <= nxt_rxCtl[p];
			end
		end
	end

	// Error insertion state.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			corrupt_ff <= '0;
			genEn_ff <= '0;
			for (int p = 0; p < NPORT; p++) begin
				phase_ff[p] <= PHASE_GOOD;
				phaseCnt_ff[p] <= '0;
			end
		end else begin
			corrupt_ff <= nxt_corrupt;
			genEn_ff <= nxt_genEn;
			for (int p = 0; p < NPORT; p++) begin
				phase_ff[p] <= nxt_phase[p];
				phaseCnt_ff[p] <= nxt_phaseCnt[p];
			end
		end
	end

	assign regRdData = rdData_ff;
	assign irq_n = irqN_ff;
	assign txCorruptCheck = corrupt_ff;
	assign checkByteGenerateEnable = genEn_ff;
	assign idlePayloadValue = idlePayload_ff;
endmodule
`default_nettype wire

// *** sim/tx_counter_status_interrupt_regs_chk.sv ***
// Checker with concurrent assertions on the port register bank.
`timescale 1ns/1ns
`default_nettype none
module tx_counter_status_interrupt_regs_chk
	import cell_regs_pkg::*;
#(
	parameter int NPORT = NUM_PORTS
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Register port.
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// Datapath and status.
	input wire logic [NPORT-1:0] txCellSent,
	input wire logic [NPORT-1:0] txParityError,
	input wire logic [NPORT-1:0] txCorruptCheck,
	input wire logic [7:0] idlePayloadValue,
	input wire logic [NPORT-1:0] rxOverrun,
	input wire logic [NPORT-1:0] lossOfDelineation,
	input wire logic [NPORT-1:0] receiverModeState,
	input wire logic [NPORT-1:0] delineationStateLsb,
	input wire logic [NPORT-1:0] delineationStateMsb,
	input wire logic [NPORT-1:0] externalStatusPin,
	input wire logic irq_n
);
	logic [3:0] liveExp_ff, nxt_liveExp;
	logic [2:0] quietCnt_ff, nxt_quietCnt;
	logic [NPORT-1:0] lossPrev_ff, pinPrev_ff;
	logic [2:0] port;
	logic stRd;
	assign port = regAddr[7:5];
	assign stRd = regRead && regAddr[4:0] == OFS_PORT_STATUS;
	// Seven quiet cycles cover the pin synchroniser, so no event can still be in flight.
	always_comb begin
		nxt_liveExp = {delineationStateMsb[port], delineationStateLsb[port],
			receiverModeState[port], lossOfDelineation[port]};
		nxt_quietCnt = (quietCnt_ff == 3'h7) ? quietCnt_ff : quietCnt_ff + 3'h1;
		if ((rxOverrun | txParityError) != '0 || lossOfDelineation != lossPrev_ff
			|| externalStatusPin != pinPrev_ff) begin
			nxt_quietCnt = 3'h0;
		end
	end
	always_ff @(posedge clk_sys) begin
		liveExp_ff <= nxt_liveExp;
		lossPrev_ff <= lossOfDelineation;
		pinPrev_ff <= externalStatusPin;
		quietCnt_ff <= reset ? 3'h0 : nxt_quietCnt;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_IDLE_RST: assert property (
		$past(reset) |-> idlePayloadValue == RST_IDLE_PAYLOAD) else $error("idle byte not reset");
	AST_IDLE_WR: assert property (
		regWrite && regAddr == ADDR_IDLE_PAYLOAD_BYTE |=> idlePayloadValue == $past(regWrData))
		else $error("idle byte not written");
	AST_IRQ_RST: assert property (
		$past(reset) |-> irq_n) else $error("interrupt active after reset");
	AST_RD_ONE: assert property (
		!$past(regRead) |-> regRdData == 8'h00) else $error("read data outside its cycle");
	AST_ALIAS: assert property (
		regRead && regAddr[4:0] == OFS_TX_CELL_COUNT_HIGH ##1
		regRead && regAddr[4:0] == OFS_TX_CELL_COUNT_HIGH |=> regRdData == $past(regRdData))
		else $error("count byte differs between aliases");
	AST_LIVE: assert property (
		stRd && lossOfDelineation == lossPrev_ff |=> regRdData[5:2] == liveExp_ff)
		else $error("status state bits wrong");
	AST_CLEAR: assert property (
		stRd && quietCnt_ff == 3'h7 ##1 stRd && $stable(regAddr) && quietCnt_ff == 3'h7
		|=> (regRdData & 8'hC3) == 8'h00) else $error("event bits not cleared by read");
	AST_CORRUPT: assert property (
		!$stable(txCorruptCheck) |-> $past(txCellSent) != '0 || $past(regWrite)
		|| $past(regWrite, 2)) else $error("corrupt flag moved without a cell");
endmodule
bind tx_counter_status_interrupt_regs tx_counter_status_interrupt_regs_chk #(.NPORT(NPORT)) i_chk (
	.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .txCellSent(txCellSent),
	.txParityError(txParityError), .txCorruptCheck(txCorruptCheck),
	.idlePayloadValue(idlePayloadValue), .rxOverrun(rxOverrun),
	.lossOfDelineation(lossOfDelineation), .receiverModeState(receiverModeState),
	.delineationStateLsb(delineationStateLsb), .delineationStateMsb(delineationStateMsb),
	.externalStatusPin(externalStatusPin), .irq_n(irq_n));
`default_nettype wire

// *** sim/tx_counter_status_interrupt_regs_bench.sv ***
// Self-checking bench for the port register bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errCount++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tx_counter_status_interrupt_regs_bench import cell_regs_pkg::*; ;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, idlePayloadValue;
	logic regWrite = 1'b0, regRead = 1'b0, irq_n;
	logic [7:0] txCellSent = '0, txCellIsIdle = '0, txParityError = '0, rxOverrun = '0;
	logic [7:0] lossOfDelineation = 8'hFF, receiverModeState = '0, externalStatusPin = '0;
	logic [7:0] delineationStateLsb = '0, delineationStateMsb = '0;
	logic [7:0] txCorruptCheck, checkByteGenerateEnable, bitv, lostv;
	int errCount = 0, cmpCount = 0, k;
	tx_counter_status_interrupt_regs i_dut (
		.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.txCellSent(txCellSent), .txCellIsIdle(txCellIsIdle), .txParityError(txParityError),
		.txCorruptCheck(txCorruptCheck), .checkByteGenerateEnable(checkByteGenerateEnable),
		.idlePayloadValue(idlePayloadValue), .rxOverrun(rxOverrun),
		.lossOfDelineation(lossOfDelineation), .receiverModeState(receiverModeState),
		.delineationStateLsb(delineationStateLsb), .delineationStateMsb(delineationStateMsb),
		.externalStatusPin(externalStatusPin), .irq_n(irq_n));
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		regRead <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Strobes stay up between calls so reads and writes can run back to back.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		regWrite <= 1'b0;
		@(posedge clk_sys);
		fork
			begin
				@(negedge clk_sys);
				`CHK($sformatf("read %h", a), e, regRdData)
			end
		join_none
	endtask
	task automatic idle();
		regRead <= 1'b0;
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic cells(input logic [7:0] m, input int n, input logic [7:0] i);
		repeat (n) begin
			txCellSent <= m;
			txCellIsIdle <= i;
			@(posedge clk_sys);
			txCellSent <= 8'h00;
			@(posedge clk_sys);
		end
	endtask
	task automatic finalReport();
		$display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		errCount++;
		finalReport();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		`CHK("idle byte", 8'h6A, idlePayloadValue)
		rd(8'h04, 8'h6A);
		rd(8'h05, RST_HEADER_ERROR_PATTERN);
		rd(8'h08, 8'h00);
		rd(8'h18, 8'h04);
		rd(8'h1F, 8'h00);
		wr(8'h04, 8'hA5);
		rd(8'h04, 8'hA5);
		idle();
		`CHK("idle byte", 8'hA5, idlePayloadValue)
		cells(8'h04, 3, 8'h00);
		cells(8'h04, 1, 8'h04);
		cells(8'h20, 300, 8'h00);
		wr(8'h41, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'hE3, 8'h03);
		wr(8'hA1, 8'h00);
		rd(8'h22, 8'h01);
		rd(8'h03, 8'h2C);
		wr(8'h02, 8'hFF);
		wr(8'h41, 8'h55);
		rd(8'hE2, 8'h01);
		rd(8'h42, 8'h01);
		rd(8'h63, 8'h2C);
		wr(8'hA1, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h00);
		wr(8'h05, 8'h0A);
		rd(8'h05, 8'h0A);
		wr(8'h06, 8'h02);
		idle();
		repeat (2) @(posedge clk_sys);
		`CHK("gen enable", 1'b0, checkByteGenerateEnable[0])
		for (k = 0; k < 6; k++) begin
			@(negedge clk_sys);
			`CHK("corrupt", (k % 3 != 0) ? 1'b1 : 1'b0, txCorruptCheck[0])
			@(posedge clk_sys);
			cells(8'h01, 1, 8'h00);
		end
		wr(8'h06, 8'h00);
		idle();
		repeat (2) @(posedge clk_sys);
		`CHK("corrupt off", 1'b0, txCorruptCheck[0])
		wr(8'h7A, 8'h38);
		wr(8'h66, 8'h45);
		rd(8'h66, 8'h45);
		rd(8'h7A, 8'h38);
		idle();
		receiverModeState <= 8'h08;
		delineationStateLsb <= 8'h08;
		for (k = 0; k < 4; k++) begin
			case (k)
				0: rxOverrun <= 8'h0A;
				1: lossOfDelineation <= 8'hF5;
				2: txParityError <= 8'h0A;
				default: externalStatusPin <= 8'h0A;
			endcase
			@(posedge clk_sys);
			rxOverrun <= 8'h00;
			txParityError <= 8'h00;
			repeat (5) @(posedge clk_sys);
			bitv = (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : (k == 2) ? 8'h40 : 8'h80;
			lostv = (k == 0) ? 8'h04 : 8'h00;
			`CHK("irq set", 1'b0, irq_n)
			rd(8'h08, 8'h08);
			rd(8'h38, bitv | lostv);
			rd(8'h78, bitv | lostv | 8'h18);
			rd(8'h08, 8'h00);
			rd(8'h78, lostv | 8'h18);
			rd(8'h78, lostv | 8'h18);
			idle();
			`CHK("irq clear", 1'b1, irq_n)
		end
		delineationStateMsb <= 8'h08;
		delineationStateLsb <= 8'h00;
		@(posedge clk_sys);
		rd(8'h78, 8'h28);
		idle();
		repeat (2) @(posedge clk_sys);
		finalReport();
	end
endmodule
`default_nettype wire
